// >>> design/power_cut_wake_source_regs.sv
// Wake source register bank with edge select, sticky status and drive bits
`timescale 1ns/10ps
// Function
// - Line B/nine edge select, 1 falling
// - Unused upper bits read zero, write zero
// - Key status flags in bits three..zero
// - Writing zero clears a status flag
// - Touch wake flag at bit six
// - Clock wake flag at bit zero
// - Line B bit one, nine bit zero
// - Flags hold until software clears
// - LCD strength bit four, resets one
// - Memory strength bits one..zero, resets 01
// - Per key enable gates wake requests
module power_cut_wake_source_regs
  import wake_regs_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        hot_reset_n_i,
  input  wire logic        clk_en_i,
  input  wire logic [11:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [3:0]  key_input_i,
  input  wire logic        touch_screen_irq_i,
  input  wire logic        rtc_wake_i,
  input  wire logic        external_line_b_i,
  input  wire logic        external_line_nine_i,
  output logic             display_port_strength_o,
  output logic [1:0]       memory_port_strength_o,
  output logic             wake_irq_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK  = 3'b010,
    ST_REL  = 3'b100
  } bus_state_t;

  bus_state_t  state_q;
  bus_state_t  state_d;
  logic [1:0]  line_edge_q;
  logic [3:0]  key_stat_q;
  logic        touch_stat_q;
  logic        clock_stat_q;
  logic [1:0]  line_stat_q;
  logic        lcd_q;
  logic [1:0]  mem_q;
  logic [3:0]  key_en_q;
  logic        touch_en_q;
  logic        clock_en_q;
  logic [1:0]  line_en_q;
  logic [NUM_SRC-1:0] irq_stat_q;
  logic [NUM_SRC-1:0] irq_mask_q;
  logic [31:0] rdata_q;
  logic        irq_q;
  logic        wait_q;
  logic [NUM_SRC-1:0] edge_w;
  logic [NUM_SRC-1:0] src_w;
  logic [NUM_SRC-1:0] fall_w;
  logic [NUM_SRC-1:0] en_w;
  logic [NUM_SRC-1:0] hit_w;
  logic [31:0] rd_mux;

  function automatic logic sel(input logic [11:0] a, input logic [11:0] o);
    sel = (a == o);
  endfunction : sel

  wire req      = (avs_read_i || avs_write_i) && state_q == ST_IDLE;
  wire wr_take  = avs_write_i && state_q == ST_ACK && clk_en_i;
  wire be0      = avs_byteenable_i[0];
  wire [7:0] wd = avs_writedata_i[7:0];
  wire wr_lined = wr_take && be0 && sel(avs_address_i, OFS_LINE_EDGE);
  wire wr_key   = wr_take && be0 && sel(avs_address_i, OFS_KEY_STAT);
  wire wr_touch = wr_take && be0 && sel(avs_address_i, OFS_TOUCH_STAT);
  wire wr_clock = wr_take && be0 && sel(avs_address_i, OFS_CLOCK_STAT);
  wire wr_lines = wr_take && be0 && sel(avs_address_i, OFS_LINE_STAT);
  wire wr_drive = wr_take && be0 && sel(avs_address_i, OFS_DRIVE);
  wire wr_keyen = wr_take && be0 && sel(avs_address_i, OFS_KEY_ENABLE);
  wire wr_tchen = wr_take && be0 && sel(avs_address_i, OFS_TOUCH_EN);
  wire wr_clken = wr_take && be0 && sel(avs_address_i, OFS_CLOCK_EN);
  wire wr_linen = wr_take && be0 && sel(avs_address_i, OFS_LINE_EN);
  wire wr_istat = wr_take && be0 && sel(avs_address_i, OFS_IRQ_STATUS);
  wire wr_imask = wr_take && be0 && sel(avs_address_i, OFS_IRQ_MASK);

  // Source order: keys 0..3, touch, clock, line nine, line B
  assign src_w  = {external_line_b_i, external_line_nine_i, rtc_wake_i,
                   touch_screen_irq_i, key_input_i};
  assign fall_w = {line_edge_q[LINE_B_BIT], line_edge_q[LINE_NINE_BIT],
                   1'b0, 1'b0, 4'h0};
  assign en_w   = {line_en_q[LINE_B_BIT], line_en_q[LINE_NINE_BIT],
                   clock_en_q, touch_en_q, key_en_q};
  assign hit_w  = edge_w & en_w;
  // Next-state view so the interrupt has no extra cycle of lag
  wire [NUM_SRC-1:0] irq_stat_d = hit_w |
                                  (irq_stat_q & ~({8{wr_istat}} & wd));
  wire [NUM_SRC-1:0] irq_mask_d = wr_imask ? wd : irq_mask_q;

  // Every source is a pin, so each gets the three-stage synchroniser
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      wake_edge_detect u_det (
        .sys_clk_i  (sys_clk_i),
        .reset_n_i  (reset_n_i),
        .clk_en_i   (clk_en_i),
        .src_i      (src_w[g]),
        .fall_sel_i (fall_w[g]),
        .edge_o     (edge_w[g])
      );
    end
  endgenerate

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (req) state_d = ST_ACK;
      ST_ACK:  state_d = ST_REL;
      ST_REL:  state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_comb begin
    rd_mux = UNMAPPED_READ;
    case (avs_address_i)
      OFS_LINE_EDGE:  rd_mux = {30'h0, line_edge_q};
      OFS_KEY_STAT:   rd_mux = {28'h0, key_stat_q};
      OFS_TOUCH_STAT: rd_mux = UNUSED_READ | (32'(touch_stat_q) << TOUCH_BIT);
      OFS_CLOCK_STAT: rd_mux = UNUSED_READ | (32'(clock_stat_q) << CLOCK_BIT);
      OFS_LINE_STAT:  rd_mux = {30'h0, line_stat_q};
      OFS_DRIVE:      rd_mux = {27'h0, lcd_q, 2'h0, mem_q};
      OFS_KEY_ENABLE: rd_mux = {28'h0, key_en_q};
      OFS_TOUCH_EN:   rd_mux = 32'(touch_en_q) << TOUCH_BIT;
      OFS_CLOCK_EN:   rd_mux = 32'(clock_en_q) << CLOCK_BIT;
      OFS_LINE_EN:    rd_mux = {30'h0, line_en_q};
      OFS_IRQ_STATUS: rd_mux = {24'h0, irq_stat_q};
      OFS_IRQ_MASK:   rd_mux = {24'h0, irq_mask_q};
      default:        rd_mux = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
      rdata_q <= 32'h0000_0000;
      wait_q  <= 1'b1;
    end else if (clk_en_i) begin
      state_q <= state_d;
      wait_q  <= (state_d != ST_ACK);
      if (req) begin
        rdata_q <= avs_read_i ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // Config held on hot reset; only full reset loads defaults
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      line_edge_q <= 2'h0;
      lcd_q       <= LCD_RESET;
      mem_q       <= MEM_RESET;
      key_en_q    <= 4'h0;
      touch_en_q  <= 1'b0;
      clock_en_q  <= 1'b0;
      line_en_q   <= 2'h0;
      irq_mask_q  <= 8'h00;
    end else if (clk_en_i) begin
      if (wr_lined) line_edge_q <= wd[1:0];
      if (wr_drive) begin
        lcd_q <= wd[LCD_BIT];
        mem_q <= wd[1:0];
      end
      if (wr_keyen) key_en_q   <= wd[3:0];
      if (wr_tchen) touch_en_q <= wd[TOUCH_BIT];
      if (wr_clken) clock_en_q <= wd[CLOCK_BIT];
      if (wr_linen) line_en_q  <= wd[1:0];
      if (wr_imask) irq_mask_q <= wd;
    end
  end

  // Flags are cleared at full reset for determinism; a set beats a clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      key_stat_q   <= 4'h0;
      touch_stat_q <= 1'b0;
      clock_stat_q <= 1'b0;
      line_stat_q  <= 2'h0;
      irq_stat_q   <= 8'h00;
      irq_q        <= 1'b0;
    end else if (clk_en_i) begin
      // Key, touch, clock and line flags: write zero clears, edge sets, else hold
      key_stat_q   <= hit_w[3:0] | (key_stat_q & ~({4{wr_key}} & ~wd[3:0]));
      touch_stat_q <= hit_w[4] | (touch_stat_q & ~(wr_touch & ~wd[TOUCH_BIT]));
      clock_stat_q <= hit_w[5] | (clock_stat_q & ~(wr_clock & ~wd[CLOCK_BIT]));
      line_stat_q  <= {hit_w[7], hit_w[6]} |
                      (line_stat_q & ~({2{wr_lines}} & ~wd[1:0]));
      irq_stat_q   <= irq_stat_d;
      irq_q        <= |(irq_stat_d & irq_mask_d);
    end
  end

  assign avs_readdata_o          = rdata_q;
  assign avs_waitrequest_o       = wait_q;
  assign display_port_strength_o = lcd_q;
  assign memory_port_strength_o  = mem_q;
  assign wake_irq_o              = irq_q;

  // An enabled edge shows in the key flag next cycle
  chk_key_flag_set: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) clk_en_i && hit_w[0] |=> key_stat_q[0])
    else $error("key flag not set after enabled edge");
  // Disabled key never sets its flag
  chk_key_enable_gate: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i && !key_en_q[0] && !key_stat_q[0] && !wr_take |=> !key_stat_q[0])
    else $error("disabled key raised a flag");
  // Zero write clears when no new edge
  chk_zero_clears: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) wr_key && !wd[0] && !hit_w[0] |=> !key_stat_q[0])
    else $error("zero write did not clear key flag");
  // Flag holds without a clearing write
  chk_flag_holds: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) touch_stat_q && !wr_touch |=> touch_stat_q)
    else $error("touch flag dropped by itself");
  chk_lcd_write: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    wr_drive |=> display_port_strength_o == $past(wd[LCD_BIT]))
    else $error("lcd strength not updated");
  chk_mem_write: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    wr_drive |=> memory_port_strength_o == $past(wd[1:0]))
    else $error("memory strength not updated");
  // Line B edge lands in bit one
  chk_line_b_flag: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) clk_en_i && hit_w[7] |=> line_stat_q[1])
    else $error("line B flag not set");
  // Bus answers in the cycle after the request
  chk_bus_answer: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) req && clk_en_i |=> !avs_waitrequest_o)
    else $error("waitrequest not released");
  // Waitrequest drops for exactly one cycle
  chk_wait_one_cycle: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    clk_en_i && !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  // Upper bits stay zero on reads
  chk_unused_zero: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000)
    else $error("unused read bits not zero");
  // Key flags read back in the low nibble
  chk_key_read: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    req && clk_en_i && avs_read_i && sel(avs_address_i, OFS_KEY_STAT)
    |=> avs_readdata_o == {28'h000_0000, $past(key_stat_q)})
    else $error("key flags not in low nibble");
  chk_touch_flag_set: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) clk_en_i && hit_w[4] |=> touch_stat_q)
    else $error("touch flag not set after enabled edge");
  chk_clock_flag_set: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) clk_en_i && hit_w[5] |=> clock_stat_q)
    else $error("clock flag not set after enabled edge");
  // Line nine edge lands in bit zero
  chk_line_nine_flag: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) clk_en_i && hit_w[6] |=> line_stat_q[0])
    else $error("line nine flag not set");
  // Line B edge matches its polarity
  chk_line_b_polarity: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    edge_w[7] |-> g_src[7].u_det.sync_q[2] != line_edge_q[LINE_B_BIT])
    else $error("line B edge of wrong polarity");
  // Line nine edge matches its polarity
  chk_line_nine_polarity: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    edge_w[6] |-> g_src[6].u_det.sync_q[2] != line_edge_q[LINE_NINE_BIT])
    else $error("line nine edge of wrong polarity");
  chk_irq_level: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) wake_irq_o == |(irq_stat_q & irq_mask_q))
    else $error("interrupt level out of step with status");
  // Drive bits change only on a write
  chk_drive_holds: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    !wr_drive |=> $stable(lcd_q) && $stable(mem_q))
    else $error("drive bits changed without a write");
  chk_freeze_flags: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    !clk_en_i |=> $stable(key_stat_q) && $stable(line_stat_q))
    else $error("flags moved while clock enable low");
endmodule : power_cut_wake_source_regs

// >>> design/wake_regs_pkg.sv
// Package with offsets, fields and reset values for the wake source registers
package wake_regs_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_LINE_EDGE   = 12'h22C;
  localparam logic [11:0] OFS_KEY_STAT    = 12'h240;
  localparam logic [11:0] OFS_TOUCH_STAT  = 12'h244;
  localparam logic [11:0] OFS_CLOCK_STAT  = 12'h248;
  localparam logic [11:0] OFS_LINE_STAT   = 12'h24C;
  localparam logic [11:0] OFS_DRIVE       = 12'h260;
  localparam logic [11:0] OFS_KEY_ENABLE  = 12'h200;
  localparam logic [11:0] OFS_TOUCH_EN    = 12'h204;
  localparam logic [11:0] OFS_CLOCK_EN    = 12'h208;
  localparam logic [11:0] OFS_LINE_EN     = 12'h20C;
  localparam logic [11:0] OFS_IRQ_STATUS  = 12'h2A0;
  localparam logic [11:0] OFS_IRQ_MASK    = 12'h2A4;
  localparam int unsigned LINE_B_BIT      = 1;
  localparam int unsigned LINE_NINE_BIT   = 0;
  localparam int unsigned TOUCH_BIT       = 6;
  localparam int unsigned CLOCK_BIT       = 0;
  localparam int unsigned LCD_BIT         = 4;
  localparam int unsigned NUM_KEYS        = 4;
  localparam int unsigned NUM_SRC         = 8;
  localparam logic        LCD_RESET       = 1'b1;
  localparam logic [1:0]  MEM_RESET       = 2'h1;
  localparam logic [31:0] UNUSED_READ     = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;
endpackage : wake_regs_pkg

// >>> design/wake_edge_detect.sv
// Input synchroniser and selectable edge detector for one wake source
`timescale 1ns/10ps
module wake_edge_detect (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic clk_en_i,
  input  wire logic src_i,
  input  wire logic fall_sel_i,
  output logic      edge_o
);
  logic [2:0] sync_q;
  logic       stable_q;
  wire        agree = (sync_q[2] == sync_q[1]);
  wire        rise  = agree && sync_q[2] && !stable_q;
  wire        fall  = agree && !sync_q[2] && stable_q;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_q   <= 3'h0;
      stable_q <= 1'b0;
    end else if (clk_en_i) begin
      sync_q <= {sync_q[1:0], src_i};
      if (agree) begin
        stable_q <= sync_q[2];
      end
    end
  end

  assign edge_o = clk_en_i && (fall_sel_i ? fall : rise);
endmodule : wake_edge_detect

// >>> sim/tb_top.sv
// Self-checking testbench for the wake source register bank
`timescale 1ns/10ps
module tb_top;
  import wake_regs_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        hot_reset_n_i = 1'b1;
  logic [11:0] avs_address_i = 12'h000;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic        clk_en_i = 1'b1;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [3:0]  key_input_i = 4'h0;
  logic        touch_screen_irq_i = 1'b0;
  logic        rtc_wake_i = 1'b0;
  logic        external_line_b_i = 1'b0;
  logic        external_line_nine_i = 1'b0;
  logic        display_port_strength_o;
  logic [1:0]  memory_port_strength_o;
  logic        wake_irq_o;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          mdl [int];
  logic [31:0] rdat;
  logic [3:0]  ken;
  logic [1:0]  sel;
  logic [4:0]  drv;
  logic [11:0] ofs [13] = '{OFS_LINE_EDGE, OFS_KEY_STAT, OFS_TOUCH_STAT,
    OFS_CLOCK_STAT, OFS_LINE_STAT, OFS_DRIVE, OFS_KEY_ENABLE, OFS_TOUCH_EN,
    OFS_CLOCK_EN, OFS_LINE_EN, OFS_IRQ_STATUS, OFS_IRQ_MASK, 12'h3F0};

  always #5 sys_clk_i = ~sys_clk_i;

  power_cut_wake_source_regs uut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .hot_reset_n_i(hot_reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .key_input_i(key_input_i), .touch_screen_irq_i(touch_screen_irq_i),
    .rtc_wake_i(rtc_wake_i), .external_line_b_i(external_line_b_i),
    .external_line_nine_i(external_line_nine_i),
    .display_port_strength_o(display_port_strength_o),
    .memory_port_strength_o(memory_port_strength_o), .wake_irq_o(wake_irq_o));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic we, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_i   <= a;
    avs_write_i     <= we;
    avs_read_i      <= !we;
    avs_writedata_i <= d;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      $display("ERROR %0t bus access never answered", $time);
    end
    rdat = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0);
    chk(rdat, mdl[a]);
  endtask : rd

  // Model clears status flags on a zero write, but clears IRQ status bits on a one write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    case (a)
      OFS_LINE_EDGE, OFS_LINE_EN: mdl[a] = d & 32'h3;
      OFS_DRIVE:      mdl[a] = d & 32'h13;
      OFS_KEY_ENABLE: mdl[a] = d & 32'hF;
      OFS_TOUCH_EN:   mdl[a] = d & 32'h40;
      OFS_CLOCK_EN:   mdl[a] = d & 32'h1;
      OFS_IRQ_MASK:   mdl[a] = d & 32'hFF;
      OFS_IRQ_STATUS: mdl[a] = mdl[a] & ~d;
      default:        mdl[a] = mdl[a] & d;
    endcase
  endtask : wr

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  initial begin : watchdog
    #200us;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin : main
    foreach (ofs[i]) mdl[ofs[i]] = 0;
    mdl[OFS_DRIVE] = 32'h11;
    void'($urandom(85634));
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    foreach (ofs[i]) rd(ofs[i]);
    chk(display_port_strength_o, LCD_RESET);
    chk(memory_port_strength_o, MEM_RESET);
    repeat (4) begin
      drv = 5'($urandom);
      wr(OFS_DRIVE, {27'h0, drv[4], 2'b00, drv[1], 1'b1});
      rd(OFS_DRIVE);
      chk(display_port_strength_o, drv[4]);
      chk(memory_port_strength_o, {drv[1], 1'b1});
    end
    // Lane 0 off: the write is dropped, so the model keeps its value
    avs_byteenable_i <= 4'hE;
    bus(1'b1, OFS_DRIVE, mdl[OFS_DRIVE] ^ 32'h12);
    avs_byteenable_i <= 4'hF;
    rd(OFS_DRIVE);
    // Power cut entry is elsewhere; sources toggle as after it
    wr(OFS_LINE_EN, 32'h3);
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      wr(OFS_LINE_EDGE, {30'h0, sel});
      wr(OFS_LINE_STAT, 32'h0);
      // Only the unselected edge or none happens here
      external_line_b_i    <= sel[1];
      external_line_nine_i <= sel[0];
      repeat (8) @(posedge sys_clk_i);
      rd(OFS_LINE_STAT);
      external_line_b_i    <= ~sel[1];
      external_line_nine_i <= ~sel[0];
      repeat (8) @(posedge sys_clk_i);
      mdl[OFS_LINE_STAT] = 32'h3;
      rd(OFS_LINE_STAT);
      rd(OFS_LINE_EDGE);
    end
    ken = 4'($urandom) | 4'h1;
    wr(OFS_KEY_ENABLE, {28'h0, ken});
    key_input_i <= 4'hF;
    repeat (8) @(posedge sys_clk_i);
    mdl[OFS_KEY_STAT] = {28'h0, ken};
    rd(OFS_KEY_STAT);
    key_input_i <= 4'h0;
    repeat (30) @(posedge sys_clk_i);
    rd(OFS_KEY_STAT);
    hot_reset_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    hot_reset_n_i <= 1'b1;
    rd(OFS_KEY_STAT);
    rd(OFS_DRIVE);
    wr(OFS_KEY_STAT, 32'h0);
    rd(OFS_KEY_STAT);
    // A pulse while the clock enable is low never reaches the flags
    clk_en_i    <= 1'b0;
    key_input_i <= 4'hF;
    repeat (6) @(posedge sys_clk_i);
    key_input_i <= 4'h0;
    repeat (6) @(posedge sys_clk_i);
    clk_en_i    <= 1'b1;
    rd(OFS_KEY_STAT);
    wr(OFS_TOUCH_EN, 32'h40);
    wr(OFS_CLOCK_EN, 32'h1);
    wr(OFS_IRQ_STATUS, 32'hFF);
    wr(OFS_IRQ_MASK, 32'h0);
    touch_screen_irq_i <= 1'b1;
    rtc_wake_i         <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    mdl[OFS_TOUCH_STAT] = 32'h40;
    mdl[OFS_CLOCK_STAT] = 32'h1;
    mdl[OFS_IRQ_STATUS] = 32'h30;
    rd(OFS_TOUCH_STAT);
    rd(OFS_CLOCK_STAT);
    rd(OFS_IRQ_STATUS);
    chk(wake_irq_o, 1'b0);
    wr(OFS_IRQ_MASK, 32'h20);
    repeat (2) @(posedge sys_clk_i);
    chk(wake_irq_o, 1'b1);
    wr(OFS_IRQ_STATUS, 32'h20);
    repeat (2) @(posedge sys_clk_i);
    chk(wake_irq_o, 1'b0);
    wr(OFS_TOUCH_STAT, 32'h0);
    wr(OFS_CLOCK_STAT, 32'h0);
    rd(OFS_TOUCH_STAT);
    rd(OFS_CLOCK_STAT);
    print_verdict();
  end
endmodule : tb_top
